//--- hdl/sfesc_pkg.sv
// Shared constants for the serial flash erase/suspend control pair
// Assumes one system clock at 25 MHz for both ends
package sfesc_pkg;
    // Command codes
    localparam logic [7:0] CMD_WREN    = 8'h06;
    localparam logic [7:0] CMD_WRDIS   = 8'h04;
    localparam logic [7:0] CMD_SSERASE = 8'h20;
    localparam logic [7:0] CMD_SERASE  = 8'hD8;
    localparam logic [7:0] CMD_BERASE  = 8'hC7;
    localparam logic [7:0] CMD_PROG    = 8'h02;
    localparam logic [7:0] CMD_SUSP    = 8'h75;
    localparam logic [7:0] CMD_RESUME  = 8'h7A;
    localparam logic [7:0] CMD_RDSR    = 8'h05;
    localparam logic [7:0] CMD_RDFSR   = 8'h70;
    // Lane modes
    localparam logic [1:0] MODE_EXT  = 2'h0;
    localparam logic [1:0] MODE_DUAL = 2'h1;
    localparam logic [1:0] MODE_QUAD = 2'h2;
    // Flag status bit positions
    localparam int FSR_PROT    = 1;
    localparam int FSR_PSUSP   = 2;
    localparam int FSR_PFAIL   = 4;
    localparam int FSR_EFAIL   = 5;
    localparam int FSR_ESUSP   = 6;
    localparam int FSR_READY   = 7;
    localparam logic [7:0] FSR_RESET = 8'h80;
    // Status register bit positions
    localparam int SR_WIP = 0;
    localparam int SR_WEL = 1;
    // Timing in microseconds and clock cycles
    localparam int CLK_MHZ                  = 25;
    localparam int SUBSECTOR_ERASE_TIME_US  = 40;
    localparam int SECTOR_ERASE_TIME_US     = 160;
    localparam int BULK_ERASE_TIME_US       = 640;
    localparam int PROG_TIME_US             = 20;
    localparam int SUSP_LAT_US              = 2;
    localparam int SUBSECTOR_ERASE_CYC      = SUBSECTOR_ERASE_TIME_US * CLK_MHZ;
    localparam int SECTOR_ERASE_CYC         = SECTOR_ERASE_TIME_US * CLK_MHZ;
    localparam int BULK_ERASE_CYC           = BULK_ERASE_TIME_US * CLK_MHZ;
    localparam int PROG_CYC                 = PROG_TIME_US * CLK_MHZ;
    localparam int SUSP_LAT_CYC             = SUSP_LAT_US * CLK_MHZ;
    // Sector and subsector address shift
    localparam int SECT_SHIFT = 16;
    localparam int SUB_SHIFT  = 12;
    // APB register offsets of the controller
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_RDATA  = 8'h0C;
    // Clock divider half period in system clocks
    localparam int SCK_HALF = 2;
endpackage : sfesc_pkg

//--- hdl/sfesc_if.sv
// Link between host controller and flash device
// Pins are single-driver; dq shows the line level from the enables
`timescale 1ns/1ps
interface sfesc_if;
    logic       cs_n;
    logic       sck;
    logic [3:0] host_dq;
    logic [3:0] host_dq_oe;
    logic [3:0] dev_dq;
    logic [3:0] dev_dq_oe;
    logic [3:0] dq;
    assign dq = (host_dq_oe & host_dq) | (dev_dq_oe & dev_dq);
    modport host (output cs_n, output sck, output host_dq, output host_dq_oe, input dq);
    modport dev  (input cs_n, input sck, output dev_dq, output dev_dq_oe, input dq);
endinterface : sfesc_if

//--- hdl/sfesc_tmr.sv
// Countdown timer for self-timed operations
// Assumes load and pause come from the owning control logic
`timescale 1ns/1ps
module sfesc_tmr #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    // Control
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_count,
    input  wire logic         i_run,
    // Status
    output logic [W-1:0]      o_left,
    output logic              o_done
);
    typedef struct packed {
        logic [W-1:0] left;
        logic         done;
    } sfesc_tmr_type;
    sfesc_tmr_type r;
    sfesc_tmr_type next_r;
    always_comb begin
        next_r      = r;
        next_r.done = 1'b0;
        if (i_load) begin
            next_r.left = i_count;
        end else if (i_run && r.left != '0) begin
            next_r.left = r.left - 1'b1;
            next_r.done = (r.left == W'(1));
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            r <= '{default: '0};
        end else begin
            r <= next_r;
        end
    end
    assign o_left = r.left;
    assign o_done = r.done;
endmodule : sfesc_tmr

//--- hdl/sfesc_dev.sv
// Flash device end: command decode, erase sequencing, suspend and resume
// Assumes the host drives cs_n and sck from the same system clock
`timescale 1ns/1ps
module sfesc_dev #(
    parameter int TW           = 16,
    parameter int SSE_CYC      = sfesc_pkg::SUBSECTOR_ERASE_CYC,
    parameter int SE_CYC       = sfesc_pkg::SECTOR_ERASE_CYC,
    parameter int BE_CYC       = sfesc_pkg::BULK_ERASE_CYC,
    parameter int PP_CYC       = sfesc_pkg::PROG_CYC,
    parameter int LAT_CYC      = sfesc_pkg::SUSP_LAT_CYC
) (
    // Clock and reset
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_RST,
    // Link
    sfesc_if.dev             LINK,
    // User side
    input  wire logic [1:0]  I_MODE,
    input  wire logic [7:0]  I_PROT_SECT,
    input  wire logic        I_PROT_EN,
    input  wire logic        I_FAIL_ERASE,
    output logic [7:0]       O_STATUS,
    output logic [7:0]       O_FLAGS
);
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_BUSY  = 5'b00010,
        ST_SWAIT = 5'b00100,
        ST_SUSP  = 5'b01000,
        ST_PAD   = 5'b10000
    } sfesc_st_type;
    typedef struct packed {
        sfesc_st_type st;
        logic         sck_d;
        logic [31:0]  sh;
        logic [5:0]   nbit;
        logic [7:0]   code;
        logic         wel;
        logic         wip;
        logic [7:0]   fsr;
        logic         op_erase;     // Running op is erase
        logic         op_bulk;
        logic [TW-1:0] lat;
        logic         nest;         // Erase suspended under program
        logic [TW-1:0] e_left;      // Saved erase remainder
        logic [7:0]   e_sect;
        logic [7:0]   lock_sect;
        logic         lock_en;
        logic [7:0]   out_sh;
        logic         out_en;
    } sfesc_dev_type;
    sfesc_dev_type r;
    sfesc_dev_type next_r;
    logic          tmr_load;
    logic [TW-1:0] tmr_count;
    logic          tmr_run;
    logic [TW-1:0] tmr_left;
    logic          tmr_done;
    logic          rise;
    logic          fall;
    logic          cs_end;
    logic [3:0]    lanes;
    logic [31:0]   sh_in;
    logic [5:0]    bits_in;
    function automatic logic is_prot(input logic en, input logic [7:0] a, input logic [7:0] b);
        return en && (a == b);
    endfunction : is_prot
    sfesc_tmr #(.W(TW)) u_tmr (
        .i_clk   (I_CLK_SYS),
        .i_rst   (I_RST),
        .i_load  (tmr_load),
        .i_count (tmr_count),
        .i_run   (tmr_run),
        .o_left  (tmr_left),
        .o_done  (tmr_done)
    );
    assign rise   = LINK.sck && !r.sck_d && !LINK.cs_n;
    assign fall   = !LINK.sck && r.sck_d && !LINK.cs_n;
    assign cs_end = LINK.cs_n && (r.nbit != 6'h00);
    assign lanes  = LINK.dq;
    always_comb begin
        next_r    = r;
        tmr_load  = 1'b0;
        tmr_count = '0;
        tmr_run   = (r.st == ST_BUSY) || (r.st == ST_SWAIT);
        sh_in     = r.sh;
        bits_in   = r.nbit;
        next_r.sck_d = LINK.sck;
        // Shift in, MSB first; code byte on lanes per mode, later bits on lane 0
        if (rise) begin
            if (r.nbit < 6'h08 && I_MODE == sfesc_pkg::MODE_QUAD) begin
                sh_in   = {r.sh[27:0], lanes};
                bits_in = r.nbit + 6'h04;
            end else if (r.nbit < 6'h08 && I_MODE == sfesc_pkg::MODE_DUAL) begin
                sh_in   = {r.sh[29:0], lanes[1:0]};
                bits_in = r.nbit + 6'h02;
            end else begin
                sh_in   = {r.sh[30:0], lanes[0]};
                bits_in = (r.nbit == 6'h3F) ? r.nbit : r.nbit + 6'h01;
            end
            next_r.sh   = sh_in;
            next_r.nbit = bits_in;
            if (bits_in == 6'h08) begin
                next_r.code = sh_in[7:0];
                // Loaded one place right: the fall ending the code shows bit 7
                if (sh_in[7:0] == sfesc_pkg::CMD_RDSR) begin
                    next_r.out_sh = {r.wip, 6'h00, r.wel};
                    next_r.out_en = 1'b1;
                end else if (sh_in[7:0] == sfesc_pkg::CMD_RDFSR) begin
                    next_r.out_sh = {r.fsr[0], r.fsr[7:1]};
                    next_r.out_en = 1'b1;
                end
            end
        end
        if (fall && r.out_en) begin
            next_r.out_sh = {r.out_sh[6:0], r.out_sh[7]};
        end
        if (LINK.cs_n) begin
            next_r.nbit   = 6'h00;
            next_r.sh     = '0;
            next_r.out_en = 1'b0;
        end
        // Timer end: finish or enter suspend
        if (tmr_done) begin
            if (r.st == ST_SWAIT || r.st == ST_BUSY) begin
                next_r.wip = 1'b0;
                next_r.fsr[sfesc_pkg::FSR_PSUSP] = 1'b0;
                next_r.fsr[sfesc_pkg::FSR_ESUSP] = r.nest;
                next_r.fsr[sfesc_pkg::FSR_READY] = 1'b1;
                next_r.st  = r.nest ? ST_SUSP : ST_IDLE;
                next_r.op_erase = r.nest;
                next_r.nest = 1'b0;
                if (r.op_erase && I_FAIL_ERASE) begin
                    next_r.fsr[sfesc_pkg::FSR_EFAIL] = 1'b1;
                    next_r.wel = 1'b0;
                end
            end
        end else if (r.st == ST_SWAIT) begin
            next_r.lat = r.lat - 1'b1;
            if (r.lat == TW'(1)) begin
                next_r.st  = ST_SUSP;
                next_r.fsr[sfesc_pkg::FSR_READY] = 1'b1;
                next_r.wip = 1'b0;
                if (r.op_erase) begin
                    next_r.e_left = tmr_left;
                end
            end
        end
        // Commands act at chip select rise
        if (cs_end) begin
            unique case (r.code)
                sfesc_pkg::CMD_WREN: begin
                    if (r.nbit == 6'h08 && r.st != ST_BUSY && r.st != ST_SWAIT) begin
                        next_r.wel = 1'b1;
                    end
                end
                sfesc_pkg::CMD_WRDIS: begin
                    if (r.nbit == 6'h08 && r.st != ST_BUSY && r.st != ST_SWAIT) begin
                        next_r.wel = 1'b0;
                    end
                end
                sfesc_pkg::CMD_SSERASE, sfesc_pkg::CMD_SERASE, sfesc_pkg::CMD_BERASE: begin
                    // Standby only, latch set, exact length
                    if (r.st == ST_IDLE && r.wel &&
                        r.nbit == ((r.code == sfesc_pkg::CMD_BERASE) ? 6'h08 : 6'h20)) begin
                        if (r.code == sfesc_pkg::CMD_BERASE ? r.lock_en
                            : is_prot(r.lock_en, r.lock_sect, r.sh[23:16])) begin
                            next_r.fsr[sfesc_pkg::FSR_PROT]  = 1'b1;
                            next_r.fsr[sfesc_pkg::FSR_EFAIL] = 1'b1;
                        end else begin
                            next_r.st  = ST_BUSY;
                            next_r.wip = 1'b1;
                            next_r.wel = 1'b0;
                            next_r.fsr[sfesc_pkg::FSR_READY] = 1'b0;
                            next_r.op_erase = 1'b1;
                            next_r.e_sect   = r.sh[23:16];
                            tmr_load  = 1'b1;
                            tmr_count = (r.code == sfesc_pkg::CMD_BERASE) ? TW'(BE_CYC)
                                      : (r.code == sfesc_pkg::CMD_SERASE) ? TW'(SE_CYC)
                                      : TW'(SSE_CYC);
                        end
                    end
                end
                sfesc_pkg::CMD_PROG: begin
                    if (r.wel && r.nbit >= 6'h20 &&
                        (r.st == ST_IDLE || (r.st == ST_SUSP && r.op_erase && !r.nest))) begin
                        if (r.st == ST_SUSP && r.sh[23:16] == r.e_sect) begin
                            next_r.fsr[sfesc_pkg::FSR_PFAIL] = 1'b1;
                        end else begin
                            next_r.nest = (r.st == ST_SUSP);
                            next_r.st   = ST_BUSY;
                            next_r.wip  = 1'b1;
                            next_r.wel  = 1'b0;
                            next_r.op_erase = 1'b0;
                            next_r.fsr[sfesc_pkg::FSR_READY] = 1'b0;
                            tmr_load  = 1'b1;
                            tmr_count = TW'(PP_CYC);
                        end
                    end
                end
                sfesc_pkg::CMD_SUSP: begin
                    if (r.st == ST_BUSY) begin
                        next_r.st  = ST_SWAIT;
                        next_r.lat = TW'(LAT_CYC);
                        if (r.op_erase) begin
                            next_r.fsr[sfesc_pkg::FSR_ESUSP] = 1'b1;
                        end else begin
                            next_r.fsr[sfesc_pkg::FSR_PSUSP] = 1'b1;
                        end
                    end
                end
                sfesc_pkg::CMD_RESUME: begin
                    if (r.st == ST_SUSP) begin
                        next_r.wip = 1'b1;
                        next_r.fsr[sfesc_pkg::FSR_READY] = 1'b0;
                        next_r.st  = ST_BUSY;
                        if (r.fsr[sfesc_pkg::FSR_PSUSP]) begin
                            next_r.fsr[sfesc_pkg::FSR_PSUSP] = 1'b0;
                            next_r.op_erase = 1'b0;
                        end else begin
                            next_r.fsr[sfesc_pkg::FSR_ESUSP] = 1'b0;
                            next_r.op_erase = 1'b1;
                            tmr_load  = 1'b1;
                            tmr_count = r.e_left;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        // Lock state sampled when no operation is busy or suspending
        if (r.st != ST_BUSY && r.st != ST_SWAIT) begin
            next_r.lock_en   = I_PROT_EN;
            next_r.lock_sect = I_PROT_SECT;
        end
    end
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            r <= '{st: ST_IDLE, fsr: sfesc_pkg::FSR_RESET, default: '0};
        end else begin
            r <= next_r;
        end
    end
    assign LINK.dev_dq    = {2'h0, r.out_sh[7], 1'b0};
    assign LINK.dev_dq_oe = {2'h0, r.out_en, 1'b0};
    assign O_STATUS = {6'h00, r.wel, r.wip};
    assign O_FLAGS  = r.fsr;
endmodule : sfesc_dev

//--- hdl/sfesc_host.sv
// Host controller end: APB orders, serial command framing
// Assumes APB master on the same clock; device on the link interface
`timescale 1ns/1ps
module sfesc_host (
    // Clock and reset
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_RST,
    // APB slave
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic [31:0]      O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    // Link
    sfesc_if.host            LINK
);
    typedef struct packed {
        logic [23:0] addr;
        logic [39:0] sh;
        logic [5:0]  nleft;
        logic        busy;
        logic [2:0]  div;
        logic        sck;
        logic        cs_n;
        logic [7:0]  rd;
        logic [3:0]  nrd;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } sfesc_host_type;
    sfesc_host_type r;
    sfesc_host_type next_r;
    logic acc;
    assign acc = I_PSEL && I_PENABLE && !r.pready;
    always_comb begin
        next_r         = r;
        next_r.pready  = 1'b0;
        next_r.pslverr = 1'b0;
        if (acc) begin
            next_r.pready = 1'b1;
            unique case (I_PADDR)
                sfesc_pkg::REG_CMD: begin
                    if (I_PWRITE && !r.busy) begin
                        // Frame: code then address bytes, MSB first
                        next_r.sh    = {I_PWDATA[7:0], r.addr, 8'h00};
                        next_r.nleft = I_PWDATA[13:8];
                        next_r.nrd   = I_PWDATA[16] ? 4'h8 : 4'h0;
                        next_r.busy  = 1'b1;
                        next_r.cs_n  = 1'b0;
                        next_r.div   = '0;
                    end
                    next_r.prdata = '0;
                end
                sfesc_pkg::REG_ADDR: begin
                    if (I_PWRITE) begin
                        next_r.addr = I_PWDATA[23:0];
                    end
                    next_r.prdata = {8'h00, r.addr};
                end
                sfesc_pkg::REG_STATUS: next_r.prdata = {31'h0, r.busy};
                sfesc_pkg::REG_RDATA:  next_r.prdata = {24'h0, r.rd};
                default: begin
                    next_r.prdata  = '0;
                    next_r.pslverr = 1'b1;
                end
            endcase
        end
        // Serial clock divider; data changes on falling, device samples rising
        if (r.busy) begin
            next_r.div = r.div + 3'h1;
            if (r.div == 3'(sfesc_pkg::SCK_HALF - 1)) begin
                next_r.div = '0;
                if (!r.sck) begin
                    next_r.sck = 1'b1;
                    if (r.nleft == 6'h00) begin
                        next_r.rd  = {r.rd[6:0], LINK.dq[1]};
                        next_r.nrd = r.nrd - 4'h1;
                    end
                end else begin
                    next_r.sck = 1'b0;
                    if (r.nleft != 6'h00) begin
                        next_r.sh    = {r.sh[38:0], 1'b0};
                        next_r.nleft = r.nleft - 6'h01;
                    end
                    if ((r.nleft == 6'h01 && r.nrd == 4'h0) ||
                        (r.nleft == 6'h00 && r.nrd == 4'h0)) begin
                        next_r.cs_n = 1'b1;
                        next_r.busy = 1'b0;
                    end
                end
            end
        end
    end
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            r      <= '{default: '0};
            r.cs_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end
    assign O_PRDATA        = r.prdata;
    assign O_PREADY        = r.pready;
    assign O_PSLVERR       = r.pslverr;
    assign LINK.cs_n       = r.cs_n;
    assign LINK.sck        = r.sck;
    assign LINK.host_dq    = {3'h0, r.sh[39]};
    assign LINK.host_dq_oe = {3'h0, r.busy && r.nleft != 6'h00};
endmodule : sfesc_host

//--- bench/sfesc_assertions.sv
// Checker on the serial link between host end and device end
// Assumes one clock; instantiated beside the link interface
`timescale 1ns/1ps
module sfesc_assertions (
    // Clock and reset
    input wire logic       I_CLK_SYS,
    input wire logic       I_RST,
    // Link
    input wire logic       cs_n,
    input wire logic       sck,
    input wire logic [3:0] host_dq,
    input wire logic [3:0] host_dq_oe,
    input wire logic [3:0] dev_dq_oe
);
    logic [7:0] rises;
    logic       sck_d;
    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (I_RST);
    // Rising serial clock edges within the open frame
    always_ff @(posedge I_CLK_SYS) begin
        sck_d <= sck;
        rises <= cs_n ? 8'h00 : rises + {7'h00, sck & ~sck_d};
    end
    sequence s_rise;
        $rose(sck);
    endsequence
    sequence s_half;
        sck ##1 !sck;
    endsequence
    a_frame_bytes: assert property ($rose(cs_n) |-> rises >= 8'h08 && rises[2:0] == 3'h0)
        else $error("frame not whole bytes");
    a_sck_idle: assert property (cs_n |-> !sck)
        else $error("clock runs while deselected");
    a_sck_half: assert property (s_rise |-> ##1 s_half)
        else $error("clock high phase not two cycles");
    a_dq_steady: assert property (sck |-> $stable(host_dq))
        else $error("host data moved while clock high");
    a_host_lane0: assert property (host_dq_oe[3:1] == 3'h0)
        else $error("host drives upper lanes");
    a_dev_quiet: assert property (cs_n && $past(cs_n) |-> dev_dq_oe == 4'h0)
        else $error("device drives while deselected");
    a_dev_lane1: assert property (dev_dq_oe[0] == 1'b0 && dev_dq_oe[3:2] == 2'h0)
        else $error("device drives a lane other than lane 1");
    a_no_clash: assert property ((host_dq_oe & dev_dq_oe) == 4'h0)
        else $error("both ends drive one lane");
endmodule : sfesc_assertions

//--- bench/serial_flash_erase_suspend_ctrl_tb_top.sv
// Bench for the host/device pair: table of command cases, then suspend nesting
// Assumes shortened self-timed counts on the device
`timescale 1ns/1ps
module serial_flash_erase_suspend_ctrl_tb_top;
    typedef struct packed {
        logic wr; logic pe; logic fl; logic [7:0] cd; logic [5:0] nb;
        logic [23:0] ad; logic er; logic [7:0] st; logic [7:0] fs;
    } sfesc_row_type;
    logic          clk = 1'b0;
    logic          rst = 1'b1;
    logic          psel = 1'b0;
    logic          pen = 1'b0;
    logic          pwr = 1'b0;
    logic [7:0]    paddr = 8'h00;
    logic [31:0]   pwdata = 32'h0;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          err;
    logic          prot_en = 1'b0;
    logic          fail = 1'b0;
    logic [1:0]    mode = sfesc_pkg::MODE_EXT;
    logic [7:0]    prot_sect = 8'h05;
    logic [7:0]    status;
    logic [7:0]    flags;
    logic [31:0]   rd;
    int            mismatches = 0;
    int            compares = 0;
    sfesc_row_type rows [10];
    sfesc_if       lnk ();
    always #20 clk = ~clk;
    sfesc_host i_sfesc_host (.I_CLK_SYS(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .LINK(lnk.host));
    sfesc_dev #(.SSE_CYC(55), .SE_CYC(400), .BE_CYC(60), .PP_CYC(300), .LAT_CYC(20))
        i_sfesc_dev (.I_CLK_SYS(clk), .I_RST(rst), .LINK(lnk.dev), .I_MODE(mode),
        .I_PROT_SECT(prot_sect), .I_PROT_EN(prot_en), .I_FAIL_ERASE(fail),
        .O_STATUS(status), .O_FLAGS(flags));
    sfesc_assertions i_sfesc_assertions (.I_CLK_SYS(clk), .I_RST(rst), .cs_n(lnk.cs_n),
        .sck(lnk.sck), .host_dq(lnk.host_dq), .host_dq_oe(lnk.host_dq_oe),
        .dev_dq_oe(lnk.dev_dq_oe));
    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out
    task automatic hang;
        mismatches++;
        close_out;
    endtask : hang
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) hang;
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic cmd(input logic [7:0] c, input logic [5:0] b, input logic rb,
                       input logic [23:0] a);
        logic [31:0] r;
        int n;
        apb(1'b1, sfesc_pkg::REG_ADDR, {8'h00, a}, r);
        apb(1'b1, sfesc_pkg::REG_CMD, {15'h0000, rb, 2'h0, b, c}, r);
        n = 0;
        do begin
            apb(1'b0, sfesc_pkg::REG_STATUS, 32'h0, r);
            n++;
        end while (r[0] !== 1'b0 && n < 100);
        if (n >= 100) hang;
    endtask : cmd
    task automatic settle(input logic rdy);
        int n;
        n = 0;
        while ((rdy ? flags[7] !== 1'b1 : status[0] !== 1'b0) && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000) hang;
    endtask : settle
    task automatic reset_dut;
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask : reset_dut
    initial begin
        rows = '{'{0,0,0,8'h06,6'h08,24'h0,0,8'h02,8'h80}, '{1,0,0,8'h04,6'h08,24'h0,0,8'h00,8'h80},
            '{0,0,0,8'h20,6'h20,24'h001000,0,8'h00,8'h80}, '{1,1,0,8'hD8,6'h20,24'h051234,0,8'h02,8'hA2},
            '{1,1,0,8'hC7,6'h08,24'h0,0,8'h02,8'hA2}, '{1,0,0,8'h20,6'h20,24'h013456,1,8'h00,8'h80},
            '{1,0,1,8'hD8,6'h20,24'h020000,1,8'h00,8'hA0}, '{1,0,0,8'hC7,6'h08,24'h0,1,8'h00,8'h80},
            '{1,0,0,8'hD8,6'h18,24'h0300,0,8'h02,8'h80}, '{1,0,0,8'h04,6'h10,24'h0,0,8'h02,8'h80}};
        for (int i = 0; i < 10; i++) begin
            reset_dut;
            prot_en <= rows[i].pe;
            fail <= rows[i].fl;
            if (rows[i].wr) cmd(8'h06, 6'h08, 1'b0, 24'h0);
            cmd(rows[i].cd, rows[i].nb, 1'b0, rows[i].ad);
            if (rows[i].er) begin
                chk("busy", {status[1:0], flags[7], 5'h00}, 8'h40);
                settle(1'b0);
            end
            chk("status", status, rows[i].st);
            chk("flags", flags, rows[i].fs);
        end
        reset_dut;
        chk("flags_reset", flags, 8'h80);
        cmd(8'h06, 6'h08, 1'b0, 24'h0);
        cmd(8'h05, 6'h08, 1'b1, 24'h0);
        apb(1'b0, sfesc_pkg::REG_RDATA, 32'h0, rd);
        chk("status_read", rd[7:0], 8'h02);
        cmd(8'h70, 6'h08, 1'b1, 24'h0);
        apb(1'b0, sfesc_pkg::REG_RDATA, 32'h0, rd);
        chk("flags_read", rd[7:0], 8'h80);
        apb(1'b0, 8'h10, 32'h0, rd);
        chk("unmapped", {7'h00, err}, 8'h01);
        // Erase suspended, program nested inside it
        cmd(8'h06, 6'h08, 1'b0, 24'h0);
        cmd(8'hD8, 6'h20, 1'b0, 24'h020000);
        cmd(8'h75, 6'h08, 1'b0, 24'h0);
        chk("erase_susp", flags, 8'h40);
        settle(1'b1);
        chk("erase_susp_rdy", flags, 8'hC0);
        cmd(8'h06, 6'h08, 1'b0, 24'h0);
        cmd(8'h20, 6'h20, 1'b0, 24'h010000);
        chk("erase_refused", status, 8'h02);
        cmd(8'h02, 6'h20, 1'b0, 24'h040000);
        chk("nest_prog", {status[3:0], flags[7:4]}, 8'h14);
        cmd(8'h75, 6'h08, 1'b0, 24'h0);
        chk("prog_susp", flags, 8'h44);
        settle(1'b1);
        chk("prog_susp_rdy", flags, 8'hC4);
        cmd(8'h7A, 6'h08, 1'b0, 24'h0);
        chk("resume", {6'h00, status[0], flags[7]}, 8'h02);
        settle(1'b0);
        chk("prog_done", flags, 8'hC0);
        cmd(8'h7A, 6'h08, 1'b0, 24'h0);
        settle(1'b0);
        chk("erase_done", {status[3:0], flags[7:4]}, 8'h08);
        // Suspend with less time left than the latency
        cmd(8'h06, 6'h08, 1'b0, 24'h0);
        cmd(8'h20, 6'h20, 1'b0, 24'h001000);
        cmd(8'h75, 6'h08, 1'b0, 24'h0);
        settle(1'b0);
        chk("short_left", {status[3:0], flags[7:4]}, 8'h08);
        cmd(8'h7A, 6'h08, 1'b0, 24'h0);
        chk("idle_resume", status, 8'h00);
        mode <= sfesc_pkg::MODE_QUAD;
        cmd(8'h06, 6'h08, 1'b0, 24'h0);
        chk("quad_lanes", status, 8'h00);
        close_out;
    end
endmodule : serial_flash_erase_suspend_ctrl_tb_top
